// [vcb_pkg.sv]
package vcb_pkg;
   localparam int unsigned CLK_HZ          = 250_000_000;
   localparam int unsigned BAUD_DEFAULT    = 115_200;
   localparam int unsigned BAUD_MIN        = 9_600;
   localparam int unsigned BAUD_MAX        = 921_600;
   localparam int unsigned DATA_BITS       = 8;
   localparam int unsigned STOP_BITS       = 1;
   localparam int unsigned DIV_W           = 16;
   localparam logic [15:0] DIV_DEFAULT     = 16'(CLK_HZ / BAUD_DEFAULT);
   localparam logic [15:0] DIV_LEAST       = 16'(CLK_HZ / BAUD_MAX);
   localparam logic [15:0] DIV_MOST        = 16'(CLK_HZ / BAUD_MIN);
   localparam int unsigned FIFO_DEPTH      = 16;
   localparam logic [15:0] SOCKET_PORT     = 16'h1325;
   localparam logic        LINE_IDLE       = 1'b1;
   localparam logic        START_LEVEL     = 1'b0;

   typedef enum logic [1:0] {
      VCB_HS_DISABLED = 2'b00,
      VCB_HS_RTS      = 2'b01,
      VCB_HS_CTS      = 2'b10,
      VCB_HS_RTSCTS   = 2'b11
   } vcb_hs_e;

   typedef enum logic [1:0] {
      VCB_SER_IDLE  = 2'b00,
      VCB_SER_START = 2'b01,
      VCB_SER_DATA  = 2'b10,
      VCB_SER_STOP  = 2'b11
   } vcb_ser_e;

   // Clamp a requested divider into the legal baud range
   function automatic logic [15:0] vcb_clamp_div(input logic [15:0] d);
      if (d < DIV_LEAST) begin
         return DIV_LEAST;
      end else if (d > DIV_MOST) begin
         return DIV_MOST;
      end
      return d;
   endfunction
endpackage

// [vcb_link_if.sv]
`timescale 1ns/10ps
interface vcb_link_if;
   logic tgt_tx;
   logic tgt_rx;
   logic tgt_rts;
   logic cts_out;
   logic cts_oe;
   logic enable;
   wire  cts_wire;
   // Pull-up: an undriven clear-to-send line reads as asserted
   assign cts_wire = cts_oe ? cts_out : 1'b1;

   modport bridge (
      input  tgt_tx,
      output tgt_rx,
      input  tgt_rts,
      output cts_out,
      output cts_oe,
      input  enable
   );
   modport target (
      output tgt_tx,
      input  tgt_rx,
      output tgt_rts,
      input  cts_wire,
      input  cts_oe,
      output enable
   );
endinterface

// [vcb_fifo.sv]
`timescale 1ns/10ps
module vcb_fifo #(
   parameter int unsigned WIDTH = 8,
   parameter int unsigned DEPTH = 16
) (
   input  wire logic             clock_in,
   input  wire logic             resetn_in,
   input  wire logic             ce_in,
   input  wire logic [WIDTH-1:0] wr_data_in,
   input  wire logic             wr_valid_in,
   output logic                  wr_ready_out,
   output logic      [WIDTH-1:0] rd_data_out,
   output logic                  rd_valid_out,
   input  wire logic             rd_ready_in
);
   localparam int unsigned AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wp_q;
   logic [AW-1:0]    rp_q;
   logic [AW:0]      cnt_q;
   wire              push;
   wire              pop;

   assign wr_ready_out = (cnt_q != (AW+1)'(DEPTH));
   assign rd_valid_out = (cnt_q != '0);
   assign rd_data_out  = mem_q[rp_q];
   assign push = ce_in && wr_valid_in && wr_ready_out;
   assign pop  = ce_in && rd_ready_in && rd_valid_out;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         wp_q  <= '0;
         rp_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= AW'(wp_q + 1'b1);
         end
         if (pop) begin
            rp_q <= AW'(rp_q + 1'b1);
         end
         cnt_q <= (AW+1)'(cnt_q + push - pop);
      end
   end

   always_ff @(posedge clock_in) begin
      if (push) begin
         mem_q[wp_q] <= wr_data_in;
      end
   end
endmodule // vcb_fifo

// [vcb_bridge.sv]
`timescale 1ns/10ps
module vcb_bridge
   import vcb_pkg::*;
#(
   parameter int unsigned DEPTH = FIFO_DEPTH
) (
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        ce_in,
   vcb_link_if.bridge       link,
   input  wire vcb_pkg::vcb_hs_e hs_mode_in,
   input  wire logic [15:0] baud_div_in,
   input  wire logic        socket_up_in,
   input  wire logic [7:0]  usb_tx_data_in,
   input  wire logic        usb_tx_valid_in,
   output logic             usb_tx_ready_out,
   input  wire logic [7:0]  sock_tx_data_in,
   input  wire logic        sock_tx_valid_in,
   output logic             sock_tx_ready_out,
   output logic [7:0]       host_rx_data_out,
   output logic             usb_rx_valid_out,
   output logic             sock_rx_valid_out,
   input  wire logic        host_rx_ready_in,
   output logic             frame_err_out
);
   import vcb_pkg::*;

   logic [15:0] div_q;
   vcb_ser_e    tx_st_q;
   vcb_ser_e    rx_st_q;
   logic [15:0] tx_cnt_q;
   logic [15:0] rx_cnt_q;
   logic [2:0]  tx_bit_q;
   logic [2:0]  rx_bit_q;
   logic [7:0]  tx_sh_q;
   logic [7:0]  rx_sh_q;
   logic        rx_s1_q;
   logic        rx_s2_q;
   logic        rts_s1_q;
   logic        rts_s2_q;
   logic        line_q;
   logic        cts_q;
   logic        cts_oe_q;
   logic        sock_q;
   logic        in_valid_q;
   logic [7:0]  in_data_q;
   logic        ferr_q;

   wire         out_fc  = hs_mode_in[0];
   wire         in_fc   = hs_mode_in[1];
   wire         tx_gate = !in_fc || rts_s2_q;
   wire         in_ready;
   wire         dn_valid;
   wire  [7:0]  dn_data;
   wire         dn_pop;
   wire  [7:0]  up_wdata = sock_q ? sock_tx_data_in : usb_tx_data_in;
   wire         up_wvalid = sock_q ? sock_tx_valid_in : usb_tx_valid_in;
   wire         up_wready;
   wire         up_valid;
   wire  [7:0]  up_data;
   wire  [15:0] half_div = {1'b0, div_q[15:1]};

   // Bytes from the host, to be sent to the target
   vcb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_down (
      .clock_in     (clock_in),
      .resetn_in    (resetn_in),
      .ce_in        (ce_in),
      .wr_data_in   (up_wdata),
      .wr_valid_in  (up_wvalid),
      .wr_ready_out (up_wready),
      .rd_data_out  (up_data),
      .rd_valid_out (up_valid),
      .rd_ready_in  (dn_pop)
   );

   // Bytes from the target, held for the host
   vcb_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_up (
      .clock_in     (clock_in),
      .resetn_in    (resetn_in),
      .ce_in        (ce_in),
      .wr_data_in   (in_data_q),
      .wr_valid_in  (in_valid_q),
      .wr_ready_out (in_ready),
      .rd_data_out  (dn_data),
      .rd_valid_out (dn_valid),
      .rd_ready_in  (host_rx_ready_in)
   );

   assign dn_pop = (tx_st_q == VCB_SER_IDLE) && up_valid && tx_gate
                   && link.enable;
   // Ready is combinational so that back-pressure reaches the host at once
   assign usb_tx_ready_out  = !sock_q && up_wready;
   assign sock_tx_ready_out = sock_q && up_wready;
   assign host_rx_data_out  = dn_data;
   assign usb_rx_valid_out  = !sock_q && dn_valid;
   assign sock_rx_valid_out = sock_q && dn_valid;
   assign frame_err_out     = ferr_q;
   assign link.tgt_rx       = line_q;
   assign link.cts_out      = cts_q;
   assign link.cts_oe       = cts_oe_q;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         div_q    <= DIV_DEFAULT;
         rx_s1_q  <= LINE_IDLE;
         rx_s2_q  <= LINE_IDLE;
         rts_s1_q <= 1'b0;
         rts_s2_q <= 1'b0;
         sock_q   <= 1'b0;
         cts_q    <= 1'b1;
         cts_oe_q <= 1'b0;
      end else if (ce_in) begin
         div_q    <= vcb_clamp_div(baud_div_in);
         rx_s1_q  <= link.tgt_tx;
         rx_s2_q  <= rx_s1_q;
         rts_s1_q <= link.tgt_rts;
         rts_s2_q <= rts_s1_q;
         // Path switch only between bytes, so no byte is split
         if (!up_wvalid && !dn_valid) begin
            sock_q <= socket_up_in;
         end
         cts_q    <= in_ready && link.enable;
         cts_oe_q <= out_fc;
      end
   end

   // Transmitter toward the target; a started byte is always finished
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_st_q  <= VCB_SER_IDLE;
         tx_cnt_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q  <= '0;
         line_q   <= LINE_IDLE;
      end else if (ce_in) begin
         case (tx_st_q)
            VCB_SER_IDLE: begin
               line_q <= LINE_IDLE;
               if (dn_pop) begin
                  tx_sh_q  <= up_data;
                  tx_cnt_q <= div_q;
                  line_q   <= START_LEVEL;
                  tx_st_q  <= VCB_SER_START;
               end
            end
            default: begin
               if (tx_cnt_q > 16'h0001) begin
                  tx_cnt_q <= 16'(tx_cnt_q - 1'b1);
               end else begin
                  tx_cnt_q <= div_q;
                  if (tx_st_q == VCB_SER_START) begin
                     line_q   <= tx_sh_q[0];
                     tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                     tx_bit_q <= '0;
                     tx_st_q  <= VCB_SER_DATA;
                  end else if (tx_st_q == VCB_SER_DATA) begin
                     if (tx_bit_q == 3'h7) begin
                        line_q  <= LINE_IDLE;
                        tx_st_q <= VCB_SER_STOP;
                     end else begin
                        line_q   <= tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= 3'(tx_bit_q + 1'b1);
                     end
                  end else begin
                     tx_st_q <= VCB_SER_IDLE;
                  end
               end
            end
         endcase
      end
   end

   // Receiver from the target, sampling mid-bit
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_st_q    <= VCB_SER_IDLE;
         rx_cnt_q   <= '0;
         rx_bit_q   <= '0;
         rx_sh_q    <= '0;
         in_valid_q <= 1'b0;
         in_data_q  <= '0;
         ferr_q     <= 1'b0;
      end else if (ce_in) begin
         in_valid_q <= 1'b0;
         case (rx_st_q)
            VCB_SER_IDLE: begin
               if (link.enable && rx_s2_q == START_LEVEL) begin
                  rx_cnt_q <= half_div;
                  rx_st_q  <= VCB_SER_START;
               end
            end
            default: begin
               if (rx_cnt_q > 16'h0001) begin
                  rx_cnt_q <= 16'(rx_cnt_q - 1'b1);
               end else begin
                  rx_cnt_q <= div_q;
                  if (rx_st_q == VCB_SER_START) begin
                     rx_bit_q <= '0;
                     rx_st_q  <= (rx_s2_q == START_LEVEL) ? VCB_SER_DATA
                                                          : VCB_SER_IDLE;
                  end else if (rx_st_q == VCB_SER_DATA) begin
                     rx_sh_q  <= {rx_s2_q, rx_sh_q[7:1]};
                     rx_bit_q <= 3'(rx_bit_q + 1'b1);
                     if (rx_bit_q == 3'h7) begin
                        rx_st_q <= VCB_SER_STOP;
                     end
                  end else begin
                     // A full buffer drops the byte; CTS should prevent it
                     in_valid_q <= rx_s2_q && in_ready;
                     in_data_q  <= rx_sh_q;
                     ferr_q     <= !rx_s2_q;
                     rx_st_q    <= VCB_SER_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule // vcb_bridge

// [vcb_target.sv]
`timescale 1ns/10ps
module vcb_target
   import vcb_pkg::*;
(
   input  wire logic        clock_in,
   input  wire logic        resetn_in,
   input  wire logic        ce_in,
   vcb_link_if.target       link,
   input  wire logic        enable_in,
   input  wire logic        hs_en_in,
   input  wire logic [15:0] baud_div_in,
   input  wire logic [7:0]  tx_data_in,
   input  wire logic        tx_valid_in,
   output logic             tx_ready_out,
   output logic [7:0]       rx_data_out,
   output logic             rx_valid_out,
   input  wire logic        rx_room_in
);
   import vcb_pkg::*;

   vcb_ser_e    tx_st_q;
   vcb_ser_e    rx_st_q;
   logic [15:0] tx_cnt_q;
   logic [15:0] rx_cnt_q;
   logic [2:0]  tx_bit_q;
   logic [2:0]  rx_bit_q;
   logic [7:0]  tx_sh_q;
   logic [7:0]  rx_sh_q;
   logic        line_q;
   logic        rts_q;
   logic        en_q;
   logic        rx_s1_q;
   logic        rx_s2_q;
   logic        cts_s1_q;
   logic        cts_s2_q;
   logic        rxv_q;
   logic [7:0]  rxd_q;

   // Undriven CTS reads as asserted
   wire cts_ok = !hs_en_in || !link.cts_oe || cts_s2_q;
   wire start  = (tx_st_q == VCB_SER_IDLE) && tx_valid_in && cts_ok;
   wire [15:0] div = vcb_clamp_div(baud_div_in);

   assign link.tgt_tx  = line_q;
   assign link.tgt_rts = rts_q;
   assign link.enable  = en_q;
   assign tx_ready_out = start;
   assign rx_data_out  = rxd_q;
   assign rx_valid_out = rxv_q;

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rts_q    <= 1'b0;
         en_q     <= 1'b0;
         rx_s1_q  <= LINE_IDLE;
         rx_s2_q  <= LINE_IDLE;
         cts_s1_q <= 1'b0;
         cts_s2_q <= 1'b0;
      end else if (ce_in) begin
         // Room must cover one more byte after RTS drops
         rts_q    <= rx_room_in;
         en_q     <= enable_in;
         rx_s1_q  <= link.tgt_rx;
         rx_s2_q  <= rx_s1_q;
         cts_s1_q <= link.cts_wire;
         cts_s2_q <= cts_s1_q;
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         tx_st_q  <= VCB_SER_IDLE;
         tx_cnt_q <= '0;
         tx_bit_q <= '0;
         tx_sh_q  <= '0;
         line_q   <= LINE_IDLE;
      end else if (ce_in) begin
         case (tx_st_q)
            VCB_SER_IDLE: begin
               line_q <= LINE_IDLE;
               if (start) begin
                  tx_sh_q  <= tx_data_in;
                  tx_cnt_q <= div;
                  line_q   <= START_LEVEL;
                  tx_st_q  <= VCB_SER_START;
               end
            end
            default: begin
               if (tx_cnt_q > 16'h0001) begin
                  tx_cnt_q <= 16'(tx_cnt_q - 1'b1);
               end else begin
                  tx_cnt_q <= div;
                  if (tx_st_q == VCB_SER_START) begin
                     line_q   <= tx_sh_q[0];
                     tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                     tx_bit_q <= '0;
                     tx_st_q  <= VCB_SER_DATA;
                  end else if (tx_st_q == VCB_SER_DATA) begin
                     if (tx_bit_q == 3'h7) begin
                        line_q  <= LINE_IDLE;
                        tx_st_q <= VCB_SER_STOP;
                     end else begin
                        line_q   <= tx_sh_q[0];
                        tx_sh_q  <= {1'b0, tx_sh_q[7:1]};
                        tx_bit_q <= 3'(tx_bit_q + 1'b1);
                     end
                  end else begin
                     tx_st_q <= VCB_SER_IDLE;
                  end
               end
            end
         endcase
      end
   end

   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         rx_st_q  <= VCB_SER_IDLE;
         rx_cnt_q <= '0;
         rx_bit_q <= '0;
         rx_sh_q  <= '0;
         rxv_q    <= 1'b0;
         rxd_q    <= '0;
      end else if (ce_in) begin
         rxv_q <= 1'b0;
         case (rx_st_q)
            VCB_SER_IDLE: begin
               if (rx_s2_q == START_LEVEL) begin
                  rx_cnt_q <= {1'b0, div[15:1]};
                  rx_st_q  <= VCB_SER_START;
               end
            end
            default: begin
               if (rx_cnt_q > 16'h0001) begin
                  rx_cnt_q <= 16'(rx_cnt_q - 1'b1);
               end else begin
                  rx_cnt_q <= div;
                  if (rx_st_q == VCB_SER_START) begin
                     rx_bit_q <= '0;
                     rx_st_q  <= (rx_s2_q == START_LEVEL) ? VCB_SER_DATA
                                                          : VCB_SER_IDLE;
                  end else if (rx_st_q == VCB_SER_DATA) begin
                     rx_sh_q  <= {rx_s2_q, rx_sh_q[7:1]};
                     rx_bit_q <= 3'(rx_bit_q + 1'b1);
                     if (rx_bit_q == 3'h7) begin
                        rx_st_q <= VCB_SER_STOP;
                     end
                  end else begin
                     rxv_q   <= rx_s2_q;
                     rxd_q   <= rx_sh_q;
                     rx_st_q <= VCB_SER_IDLE;
                  end
               end
            end
         endcase
      end
   end
endmodule // vcb_target

// [vcb_link_props.sv]
`timescale 1ns/10ps
module vcb_link_props #(
   parameter int unsigned DIV = 271
) (
   input wire logic clock_in,
   input wire logic resetn_in,
   input wire logic tgt_tx,
   input wire logic tgt_rx,
   input wire logic cts_out,
   input wire logic cts_oe,
   input wire logic enable
);
   localparam int LAST = 10 * DIV - 2;
   localparam int STOP = 9 * DIV + DIV / 2;
   logic [1:0]  prev_q;
   logic [1:0]  in_q;
   logic [15:0] cnt_q [2];
   wire  [1:0]  line  = {tgt_tx, tgt_rx};
   wire  [1:0]  start = ~in_q & prev_q & ~line;
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (!resetn_in);
   // Frame ends two cycles early so a start right after the stop is seen
   always_ff @(posedge clock_in or negedge resetn_in) begin
      if (!resetn_in) begin
         prev_q   <= 2'h3;
         in_q     <= 2'h0;
         cnt_q[0] <= 16'h0;
         cnt_q[1] <= 16'h0;
      end else begin
         prev_q <= line;
         for (int i = 0; i < 2; i++) begin
            if (start[i]) begin
               in_q[i]  <= 1'b1;
               cnt_q[i] <= 16'h1;
            end else if (in_q[i] && cnt_q[i] == 16'(LAST)) begin
               in_q[i] <= 1'b0;
            end else if (in_q[i]) begin
               cnt_q[i] <= cnt_q[i] + 16'h1;
            end
         end
      end
   end
   AST_RESET_IDLE:
   assert property ($rose(resetn_in) |-> tgt_rx && tgt_tx && !cts_oe)
      else $error("Lines not idle after reset");
   AST_RX_START_EN:
   assert property (start[0] |-> enable || $past(enable))
      else $error("Bridge started a byte while disabled");
   AST_TX_START_EN:
   assert property (start[1] |-> enable || $past(enable))
      else $error("Target started a byte while disabled");
   AST_RX_BIT_EDGE:
   assert property (in_q[0] && $changed(tgt_rx) |-> cnt_q[0] % DIV == 0)
      else $error("Bridge line changed inside a bit");
   AST_TX_BIT_EDGE:
   assert property (in_q[1] && $changed(tgt_tx) |-> cnt_q[1] % DIV == 0)
      else $error("Target line changed inside a bit");
   AST_RX_START_LOW:
   assert property (in_q[0] && cnt_q[0] < DIV |-> !tgt_rx)
      else $error("Bridge start bit too short");
   AST_TX_START_LOW:
   assert property (in_q[1] && cnt_q[1] < DIV |-> !tgt_tx)
      else $error("Target start bit too short");
   AST_RX_STOP_HIGH:
   assert property (in_q[0] && cnt_q[0] == STOP |-> tgt_rx)
      else $error("Bridge stop bit low");
   AST_TX_STOP_HIGH:
   assert property (in_q[1] && cnt_q[1] == STOP |-> tgt_tx)
      else $error("Target stop bit low");
   AST_TX_HALT:
   assert property ((cts_oe && !cts_out) [*8] |-> !start[1])
      else $error("Target started a byte while held off");
endmodule // vcb_link_props

// [virtual_com_uart_bridge_test.sv]
`timescale 1ns/10ps
`define CHK(nm, e, a) begin checked++; if ((a) !== (e)) begin \
   num_errors++; $display("CHECK FAILED %s exp %0h got %0h", nm, e, a); \
   end end
module virtual_com_uart_bridge_test;
   import vcb_pkg::*;
   localparam int unsigned DIV = 271;
   localparam int unsigned DEP = 4;
   logic        clock_in = 1'b0;
   logic        resetn_in = 1'b0;
   vcb_hs_e     hs_mode = VCB_HS_DISABLED;
   logic [15:0] baud = 16'h0040;
   logic        sock_up = 1'b0, usb_v = 1'b0, sock_v = 1'b0, h_rdy = 1'b1;
   logic [7:0]  h_data = 8'h00, t_data = 8'h00, h_rx, t_rx;
   logic        en = 1'b1, t_v = 1'b0, room = 1'b1;
   logic        usb_r, sock_r, usb_rv, sock_rv, f_err, t_r, t_rv;
   int          num_errors = 0, checked = 0;
   logic [31:0] seed = 32'hA1CB;
   logic [7:0]  exp_t[$];
   logic [8:0]  exp_h[$];
   logic [7:0]  got_t;
   logic [8:0]  got_h;
   logic [9:0]  hw;
   always #2 clock_in = ~clock_in;
   vcb_link_if vcb_link_if_inst ();
   vcb_bridge #(.DEPTH(DEP)) vcb_bridge_inst (.clock_in(clock_in),
      .resetn_in(resetn_in), .ce_in(1'b1), .link(vcb_link_if_inst.bridge),
      .hs_mode_in(hs_mode), .baud_div_in(baud), .socket_up_in(sock_up),
      .usb_tx_data_in(h_data), .usb_tx_valid_in(usb_v),
      .usb_tx_ready_out(usb_r), .sock_tx_data_in(h_data),
      .sock_tx_valid_in(sock_v), .sock_tx_ready_out(sock_r),
      .host_rx_data_out(h_rx), .usb_rx_valid_out(usb_rv),
      .sock_rx_valid_out(sock_rv), .host_rx_ready_in(h_rdy),
      .frame_err_out(f_err));
   vcb_target vcb_target_inst (.clock_in(clock_in), .resetn_in(resetn_in),
      .ce_in(1'b1), .link(vcb_link_if_inst.target), .enable_in(en),
      .hs_en_in(1'b1), .baud_div_in(baud), .tx_data_in(t_data),
      .tx_valid_in(t_v), .tx_ready_out(t_r), .rx_data_out(t_rx),
      .rx_valid_out(t_rv), .rx_room_in(room));
   vcb_link_props #(.DIV(DIV)) vcb_link_props_inst (.clock_in(clock_in),
      .resetn_in(resetn_in), .tgt_tx(vcb_link_if_inst.tgt_tx),
      .tgt_rx(vcb_link_if_inst.tgt_rx), .cts_out(vcb_link_if_inst.cts_out),
      .cts_oe(vcb_link_if_inst.cts_oe), .enable(vcb_link_if_inst.enable));
   function automatic logic [7:0] rnd();
      seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
      return seed[7:0];
   endfunction
   task automatic end_of_test();
      $display("Checks %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic timed_out(input string w);
      num_errors++;
      $display("CHECK FAILED %s exp done got timeout", w);
      end_of_test();
   endtask
   task automatic host_send(input logic sk, input logic [7:0] d);
      int i;
      @(negedge clock_in);
      h_data = d;
      usb_v  = !sk;
      sock_v = sk;
      for (i = 0; i < 200; i++) begin
         @(posedge clock_in);
         if ((sk ? sock_r : usb_r) === 1'b1) break;
      end
      if (i == 200) timed_out("host ready");
      exp_t.push_back(d);
      @(negedge clock_in);
      usb_v  = 1'b0;
      sock_v = 1'b0;
   endtask
   task automatic tgt_send(input logic [7:0] d, input int lim,
                           output logic ok);
      @(negedge clock_in);
      t_data = d;
      t_v    = 1'b1;
      ok     = 1'b0;
      for (int i = 0; i < lim && !ok; i++) begin
         @(posedge clock_in);
         ok = (t_r === 1'b1);
      end
      if (ok) exp_h.push_back({sock_up, d});
      @(negedge clock_in);
      t_v = 1'b0;
   endtask
   task automatic drain(input string w);
      int i;
      for (i = 0; i < 30000; i++) begin
         if (exp_t.size() == 0 && exp_h.size() == 0) break;
         @(negedge clock_in);
      end
      if (i == 30000) timed_out(w);
      $display("Test %s done", w);
   endtask
   always @(posedge clock_in) begin
      if (t_rv === 1'b1) begin
         got_t = exp_t.pop_front();
         `CHK("target data", got_t, t_rx)
      end
      if (((usb_rv | sock_rv) & h_rdy) === 1'b1) begin
         got_h = exp_h.pop_front();
         hw    = {got_h[8], !got_h[8], got_h[7:0]};
         `CHK("host data", hw, {sock_rv, usb_rv, h_rx})
      end
   end
   // Decodes the bridge line on its own so a shared bit order slip shows
   always begin : wire_mon
      logic [9:0] bits;
      logic [7:0] want;
      @(negedge vcb_link_if_inst.tgt_rx);
      want = exp_t[0];
      repeat (DIV / 2) @(posedge clock_in);
      for (int k = 0; k < 10; k++) begin
         bits[k] = vcb_link_if_inst.tgt_rx;
         if (k < 9) repeat (DIV) @(posedge clock_in);
      end
      `CHK("rx line frame", {1'b1, want, 1'b0}, bits)
   end
   initial begin
      logic ok;
      repeat (20) @(posedge clock_in);
      @(negedge clock_in);
      resetn_in = 1'b1;
      baud = 16'hFFFF;
      `CHK("dflt div", 16'(250_000_000 / 115200), vcb_bridge_inst.div_q)
      @(negedge clock_in);
      baud = 16'h0040;
      `CHK("div slow", 16'(250_000_000 / 9600), vcb_bridge_inst.div_q)
      @(negedge clock_in);
      `CHK("div fast", 16'(250_000_000 / 921600), vcb_bridge_inst.div_q)
      for (int s = 0; s < 2; s++) begin
         sock_up = s[0];
         host_send(s[0], rnd());
         `CHK("path ready", {s[0], !s[0]}, {sock_r, usb_r})
         tgt_send(rnd(), 5000, ok);
         `CHK("target took", 1'b1, ok)
         drain(s[0] ? "socket" : "usb");
      end
      sock_up = 1'b0;
      room = 1'b0;
      for (int m = 0; m < 4; m++) begin
         hs_mode = vcb_hs_e'(m[1:0]);
         repeat (20) @(negedge clock_in);
         `CHK("rts level", 1'b0, vcb_link_if_inst.tgt_rts)
         host_send(1'b0, rnd());
         repeat (3000) @(negedge clock_in);
         `CHK("held bytes", m[1] ? 1 : 0, exp_t.size())
         `CHK("cts drive", m[0], vcb_link_if_inst.cts_oe)
         room = 1'b1;
         // Drop RTS inside the start bit where RTS held the byte (m[1] set); the byte must still finish
         for (int w = 0; w < 100 && vcb_link_if_inst.tgt_rx; w++) begin
            @(negedge clock_in);
         end
         room = 1'b0;
         drain("handshake mode");
         `CHK("finished byte", 0, exp_t.size())
      end
      room = 1'b1;
      hs_mode = VCB_HS_RTS;
      h_rdy = 1'b0;
      for (int n = 0; n < DEP; n++) begin
         tgt_send(rnd(), 5000, ok);
         `CHK("fill took", 1'b1, ok)
      end
      repeat (12 * DIV) @(negedge clock_in);
      `CHK("cts full", 1'b0, vcb_link_if_inst.cts_wire)
      tgt_send(rnd(), 30 * DIV, ok);
      `CHK("target held", 1'b0, ok)
      h_rdy = 1'b1;
      tgt_send(rnd(), 5000, ok);
      `CHK("resumed", 1'b1, ok)
      drain("buffer full");
      en = 1'b0;
      repeat (20) @(negedge clock_in);
      host_send(1'b0, rnd());
      repeat (3000) @(negedge clock_in);
      `CHK("disabled hold", 1, exp_t.size())
      en = 1'b1;
      drain("enable");
      `CHK("frame error", 1'b0, f_err)
      end_of_test();
   end
endmodule // virtual_com_uart_bridge_test
